// ### fps_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "fps_params.svh"
// How it works
// R01: program is two unlocks, setup, address/data
// R02: after last write, only status polling
// R03: device returns to array read itself
// R04: no commands written while program runs
// R05: hardware reset aborts; software reissues program
// R06: any address order accepted, no restriction
// R07: final readback mismatch reports failure
// R08: polling starts after final write strobe rises
// R09: status reads use the program address
// R10: erase polling reads zero until done
// R11: array data taken one read after settling
// R12: ready/busy pin open drain, low busy
// R13: toggle bit one inverts per read while busy
// R14: toggle bit two marks erasing sectors
// R15: two reads compared; equal means finished
// R16: toggling with time limit: recheck, then reset
// R17: resumed polling restarts from first read
// R18: time limit bit set on pulse overrun
// R19: reset command before further operations
// R20: program shows time limit zero, busy low
// R21: reset command address is don't care
// R22: unlock and setup codes are parameters
module fps_ctrl
  import fps_pkg::*;
#(
  parameter logic [19:0] UNLOCK1_ADDR = `FPS_UNLOCK1_ADDR,
  parameter logic [7:0]  UNLOCK1_DATA = `FPS_UNLOCK1_DATA,
  parameter logic [19:0] UNLOCK2_ADDR = `FPS_UNLOCK2_ADDR,
  parameter logic [7:0]  UNLOCK2_DATA = `FPS_UNLOCK2_DATA,
  parameter logic [7:0]  SETUP_CMD    = `FPS_SETUP_CMD,
  parameter logic [7:0]  RESET_CMD    = `FPS_RESET_CMD
)(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  // flash pins
  output logic [19:0]      FL_ADDR,
  input  wire logic [7:0]  FL_DQ_IN,
  output logic [7:0]       FL_DQ_OUT,
  output logic             FL_DQ_OE,
  output logic             FL_CE_N,
  output logic             FL_WE_N,
  output logic             FL_OE_N,
  output logic             FL_RESET_N,
  input  wire logic        FL_READY_BUSY
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    fps_state_t  st;
    logic [7:0]  cnt;       // phase timer
    logic [1:0]  wr_idx;    // bus write within the sequence
    logic        reset_cmd; // single reset-command write in progress
    logic        pair2;     // second read of a toggle pair
    logic        tog_a;     // toggle bit from first read
    logic        recheck;   // time limit seen, one more pair
    logic        final_rd;  // read that fetches settled data
    logic [7:0]  rd_data;
    logic        busy;
    logic        done;
    logic        fail;
    logic        aborted;
    logic [2:0]  wr_seen;   // write strobes since go
    logic [7:0]  last_wr;   // last byte written
    fps_pin_t    pin;
  } fps_seq_t;
  localparam fps_pin_t PIN_IDLE = '{addr: 20'h00000, dq: 8'h00, dq_oe: 1'b0,
                                    ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                    rst_n: 1'b1};
  fps_seq_t    q, d;
  fps_cmd_t    cmd;
  fps_status_t status;
  logic [19:0] wa;          // address of current write
  logic [7:0]  wd;          // data of current write
  logic        tog;
  // ----------------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------------
  fps_regs i_fps_regs (
    .MCLK      (MCLK),
    .RST_N     (RST_N),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hready    (HREADY),
    .hwdata    (HWDATA),
    .hreadyout (HREADYOUT),
    .hrdata    (HRDATA),
    .hresp     (HRESP),
    .status    (status),
    .cmd       (cmd)
  );
  // hsize is always a word; nothing to steer
  logic unused_hsize;
  assign unused_hsize = ^HSIZE;
  // status word
  always_comb begin
    status         = '0;
    status.rd_data = q.rd_data;
    status.rdy_pin = FL_READY_BUSY;  // R12
    status.aborted = q.aborted;
    status.fail    = q.fail;
    status.done    = q.done;
    status.busy    = q.busy;
  end
  // ----------------------------------------------------------------------
  // write cycle content
  // ----------------------------------------------------------------------
  always_comb begin
    wa = cmd.addr;
    wd = cmd.data;
    if (q.reset_cmd) begin
      wa = 20'h00000;                 // R21
      wd = RESET_CMD;
    end else begin
      case (q.wr_idx)                 // R01 R22
        2'd0: begin wa = UNLOCK1_ADDR; wd = UNLOCK1_DATA; end
        2'd1: begin wa = UNLOCK2_ADDR; wd = UNLOCK2_DATA; end
        2'd2: begin wa = UNLOCK1_ADDR; wd = SETUP_CMD;    end
        default: begin wa = cmd.addr;  wd = cmd.data;     end // R06
      endcase
    end
  end
  assign tog = q.rd_data[`FPS_TOG1_BIT];
  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    case (q.st)
      // wait for an order; program and reset-command goes are dropped while busy
      S_IDLE: begin
        d.pin = PIN_IDLE;
        if (cmd.go_prog || cmd.go_rstcmd) begin
          d.busy      = 1'b1;
          d.done      = 1'b0;
          d.fail      = 1'b0;
          d.aborted   = 1'b0;
          d.reset_cmd = cmd.go_rstcmd && !cmd.go_prog;
          d.wr_idx    = 2'd0;
          d.wr_seen   = 3'd0;
          d.pair2     = 1'b0;               // R17
          d.recheck   = 1'b0;
          d.final_rd  = 1'b0;
          d.st        = S_WR_SET;
        end
      end
      // address, data and chip select ahead of the strobe
      S_WR_SET: begin
        d.pin.addr  = wa;
        d.pin.dq    = wd;
        d.pin.dq_oe = 1'b1;
        d.pin.ce_n  = 1'b0;
        d.pin.we_n  = 1'b1;
        d.cnt       = `FPS_WP_CYC;
        d.st        = S_WR_LOW;
      end
      // write strobe low for the pulse width
      S_WR_LOW: begin
        if (q.cnt == 8'h00) begin
          d.pin.we_n = 1'b1;
          d.pin.ce_n = 1'b1;
          d.last_wr  = q.pin.dq;
          d.cnt      = `FPS_WPH_CYC;
          d.st       = S_WR_REC;
        end else begin
          d.pin.we_n = 1'b0;
          if (q.cnt == `FPS_WP_CYC) begin
            d.wr_seen = q.wr_seen + 3'd1;
          end
          d.cnt = q.cnt - 8'h01;
        end
      end
      // data held past the rising strobe, then next step
      S_WR_REC: begin
        if (q.cnt != 8'h00) begin
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.pin.dq_oe = 1'b0;
          if (q.reset_cmd) begin
            d.reset_cmd = 1'b0;           // R19
            d.busy      = 1'b0;
            d.done      = 1'b1;
            d.st        = S_IDLE;
          end else if (q.wr_idx == 2'd3) begin
            d.st = S_RD_SET;              // R02 R08
          end else begin
            d.wr_idx = q.wr_idx + 2'd1;
            d.st     = S_WR_SET;
          end
        end
      end
      // status reads always at the program address
      S_RD_SET: begin
        d.pin.addr  = cmd.addr;           // R09 R10
        d.pin.dq_oe = 1'b0;
        d.pin.ce_n  = 1'b0;
        d.cnt       = `FPS_ACC_CYC;
        d.st        = S_RD_LOW;
      end
      // output enable low for the access time, sample at the end
      S_RD_LOW: begin
        if (q.cnt == 8'h00) begin
          d.rd_data  = FL_DQ_IN;
          d.pin.oe_n = 1'b1;
          d.pin.ce_n = 1'b1;
          d.cnt      = `FPS_RDH_CYC;
          d.st       = S_RD_REC;
        end else begin
          d.pin.oe_n = 1'b0;
          d.cnt      = q.cnt - 8'h01;
        end
      end
      // judge the read; polling never writes until it ends
      S_RD_REC: begin
        if (q.cnt != 8'h00) begin
          d.cnt = q.cnt - 8'h01;
        end else if (q.final_rd) begin
          d.busy = 1'b0;                  // R03
          d.done = 1'b1;
          d.fail = (q.rd_data != cmd.data); // R07
          d.st   = S_IDLE;
        end else if (!q.pair2) begin
          d.tog_a = tog;                  // R13
          d.pair2 = 1'b1;
          d.st    = S_RD_SET;
        end else begin
          d.pair2 = 1'b0;
          d.st    = S_RD_SET;
          if (tog == q.tog_a) begin
            d.final_rd = 1'b1;            // R15 R11
          end else if (q.recheck) begin
            d.fail      = 1'b1;           // R16
            d.reset_cmd = 1'b1;
            d.st        = S_WR_SET;
          end else if (q.rd_data[`FPS_TLE_BIT]) begin
            d.recheck = 1'b1;             // R18
          end
        end
      end
      // hardware reset held low, then recovery
      S_HWRST: begin
        d.pin = PIN_IDLE;
        if (q.cnt == 8'h00) begin
          d.cnt = `FPS_RH_CYC;
          d.st  = S_HW_REC;
        end else begin
          d.pin.rst_n = 1'b0;
          d.cnt       = q.cnt - 8'h01;
        end
      end
      S_HW_REC: begin
        if (q.cnt != 8'h00) begin
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st   = S_IDLE;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    // hardware reset wins over everything, aborting a program
    if (cmd.go_hwrst) begin
      d.aborted   = q.busy;               // R05
      d.busy      = 1'b1;
      d.done      = 1'b0;
      d.reset_cmd = 1'b0;
      d.pin       = PIN_IDLE;
      d.pin.rst_n = 1'b0;                 // pin drops on this edge, not the next
      d.cnt       = `FPS_RP_CYC - 8'h01;  // this edge is the first low cycle
      d.st        = S_HWRST;
    end
  end
  // register the state
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      q     <= '0;
      q.st  <= S_IDLE;
      q.pin <= PIN_IDLE;
    end else begin
      q <= d;
    end
  end
  assign FL_ADDR    = q.pin.addr;
  assign FL_DQ_OUT  = q.pin.dq;
  assign FL_DQ_OE   = q.pin.dq_oe;
  assign FL_CE_N    = q.pin.ce_n;
  assign FL_WE_N    = q.pin.we_n;
  assign FL_OE_N    = q.pin.oe_n;
  assign FL_RESET_N = q.pin.rst_n;
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_four_writes;
    @(posedge MCLK) disable iff (!RST_N)
      $fell(FL_OE_N) |-> q.wr_seen == 3'd4;
  endproperty
  a_four_writes: assert property (p_four_writes) else $error("not four writes"); // R01
  property p_no_wr_poll;
    @(posedge MCLK) disable iff (!RST_N)
      (q.st == S_RD_LOW) |-> FL_WE_N && !FL_DQ_OE;
  endproperty
  a_no_wr_poll: assert property (p_no_wr_poll) else $error("write during poll"); // R04
  property p_hwrst;
    @(posedge MCLK) disable iff (!RST_N)
      cmd.go_hwrst |=> !FL_RESET_N ##1 (!FL_RESET_N)[*8];
  endproperty
  a_hwrst: assert property (p_hwrst) else $error("reset pin not held"); // R05
  property p_fail_reset;
    @(posedge MCLK) disable iff (!RST_N)
      $rose(q.fail) && q.reset_cmd |-> ##[1:40] (q.last_wr == RESET_CMD && q.done);
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("no reset after fail"); // R16
  property p_we_width;
    @(posedge MCLK) disable iff (!RST_N)
      $fell(FL_WE_N) |-> (!FL_WE_N && !FL_CE_N)[*4] ##1 FL_WE_N;
  endproperty
  a_we_width: assert property (p_we_width) else $error("strobe width"); // R01
  property p_rd_addr;
    @(posedge MCLK) disable iff (!RST_N)
      !FL_OE_N |-> FL_ADDR == cmd.addr && !FL_DQ_OE;
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("poll address"); // R09
  property p_pair;
    @(posedge MCLK) disable iff (!RST_N)
      $rose(q.final_rd) |-> $past(q.pair2) && $past(tog) == $past(q.tog_a);
  endproperty
  a_pair: assert property (p_pair) else $error("pair compare"); // R15
  property p_reset_addr;
    @(posedge MCLK) disable iff (!RST_N)
      $fell(FL_WE_N) && q.reset_cmd |-> FL_ADDR == 20'h00000 && FL_DQ_OUT == RESET_CMD;
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("reset write"); // R21
endmodule : fps_ctrl
`default_nettype wire

// ### fps_params.svh
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH
// ----------------------------------------------------------------------
// widths and clock
// ----------------------------------------------------------------------
`define FPS_ADDR_W         20
`define FPS_CLK_PERIOD_NS  10
// ----------------------------------------------------------------------
// pin timing, times in ns, counts derived (minimums round up)
// ----------------------------------------------------------------------
`define FPS_T_WP_NS   35
`define FPS_T_WPH_NS  20
`define FPS_T_ACC_NS  70
`define FPS_T_RDH_NS  20
`define FPS_T_RP_NS   500
`define FPS_T_RH_NS   50
`define FPS_CYC(t) (((t) + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS)
`define FPS_WP_CYC  8'(`FPS_CYC(`FPS_T_WP_NS))
`define FPS_WPH_CYC 8'(`FPS_CYC(`FPS_T_WPH_NS))
`define FPS_ACC_CYC 8'(`FPS_CYC(`FPS_T_ACC_NS))
`define FPS_RDH_CYC 8'(`FPS_CYC(`FPS_T_RDH_NS))
`define FPS_RP_CYC  8'(`FPS_CYC(`FPS_T_RP_NS))
`define FPS_RH_CYC  8'(`FPS_CYC(`FPS_T_RH_NS))
// ----------------------------------------------------------------------
// command sequence codes
// ----------------------------------------------------------------------
`define FPS_UNLOCK1_ADDR 20'h00555
`define FPS_UNLOCK1_DATA 8'hAA
`define FPS_UNLOCK2_ADDR 20'h002AA
`define FPS_UNLOCK2_DATA 8'h55
`define FPS_SETUP_CMD    8'hA0
`define FPS_RESET_CMD    8'hF0
// ----------------------------------------------------------------------
// status bit positions on the data byte
// ----------------------------------------------------------------------
`define FPS_TOG1_BIT 6
`define FPS_TLE_BIT  5
// ----------------------------------------------------------------------
// register offsets and control fields
// ----------------------------------------------------------------------
`define FPS_REG_CTRL   8'h00
`define FPS_REG_ADDR   8'h04
`define FPS_REG_DATA   8'h08
`define FPS_REG_STATUS 8'h0C
`define FPS_CTRL_PROG  0
`define FPS_CTRL_RST   1
`define FPS_CTRL_HWRST 2
`endif

// ### fps_pkg.sv
package fps_pkg;
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_WR_SET, S_WR_LOW, S_WR_REC,
    S_RD_SET, S_RD_LOW, S_RD_REC, S_HWRST, S_HW_REC
  } fps_state_t;
  // registered flash pin drive
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        rst_n;
  } fps_pin_t;
  // status word seen by software
  typedef struct packed {
    logic [15:0] zero_hi;
    logic [7:0]  rd_data;
    logic [2:0]  zero_lo;
    logic        rdy_pin;
    logic        aborted;
    logic        fail;
    logic        done;
    logic        busy;
  } fps_status_t;
  // orders from software, one-cycle pulses plus operands
  typedef struct packed {
    logic        go_prog;
    logic        go_rstcmd;
    logic        go_hwrst;
    logic [19:0] addr;
    logic [7:0]  data;
  } fps_cmd_t;
endpackage : fps_pkg

// ### fps_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "fps_params.svh"
module fps_regs
  import fps_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // sequencer side
  input  wire fps_status_t status,
  output fps_cmd_t         cmd
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        ph_v;     // write data phase pending
    logic [7:0]  ph_addr;  // latched offset
    logic [31:0] rdata;    // read data for the data phase
    fps_cmd_t    cmd;
  } fps_ahb_t;
  fps_ahb_t q, d;
  // next state: zero wait states, read data taken at address phase
  always_comb begin
    d = q;
    d.cmd.go_prog   = 1'b0;
    d.cmd.go_rstcmd = 1'b0;
    d.cmd.go_hwrst  = 1'b0;
    // write data phase
    if (q.ph_v) begin
      if (q.ph_addr == `FPS_REG_CTRL) begin
        d.cmd.go_prog   = hwdata[`FPS_CTRL_PROG];
        d.cmd.go_rstcmd = hwdata[`FPS_CTRL_RST];
        d.cmd.go_hwrst  = hwdata[`FPS_CTRL_HWRST];
      end else if (q.ph_addr == `FPS_REG_ADDR) begin
        d.cmd.addr = hwdata[19:0];
      end else if (q.ph_addr == `FPS_REG_DATA) begin
        d.cmd.data = hwdata[7:0];
      end
    end
    d.ph_v = 1'b0;
    // address phase
    if (hsel && hready && htrans[1]) begin
      d.ph_v    = hwrite;
      d.ph_addr = haddr[7:0];
      // unmapped offsets read as zero
      if (haddr[7:0] == `FPS_REG_ADDR) begin
        d.rdata = {12'h000, q.cmd.addr};
      end else if (haddr[7:0] == `FPS_REG_DATA) begin
        d.rdata = {24'h000000, q.cmd.data};
      end else if (haddr[7:0] == `FPS_REG_STATUS) begin
        d.rdata = status;
      end else begin
        d.rdata = 32'h00000000;
      end
    end
  end
  // register the state
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;
  assign cmd       = q.cmd;
endmodule : fps_regs
`default_nettype wire

// ### fps_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fps_params.svh"
module fps_flash_model
  import fps_pkg::*;
#(
  parameter int PROG_NS = 2000  // internal program time, plain default
)(
  // pins from the controller
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  dq_in,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        reset_n,
  // pins back to the controller
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  output logic             rb_low,
  // bench control and tallies
  input  wire logic        fail_mode,
  output logic [7:0]       n_busy_wr,
  output logic [7:0]       n_bad_rd
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]  mem [int];      // sparse array, erased cells read all ones
  logic [1:0]  step;           // position in the command sequence
  logic        busy, tle, tog; // algorithm running, limit hit, toggle bit one
  logic        armed;          // a write cycle is open
  logic [19:0] pa, wa;         // program address, write address
  logic [7:0]  pd, wd, rbyte;  // program datum, write datum, read byte
  int          gen;            // bumped on abort so a stale finish is dropped
  initial begin
    {step, busy, tle, tog, armed, gen} = '0;
    {dq_oe, n_busy_wr, n_bad_rd} = '0;
    dq_out = 8'hFF;
  end
  function automatic logic [7:0] rd_mem(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd_mem
  assign rb_low = busy;
  // ----------------------------------------------------------------------
  // write cycles: address and data steady from the falling strobe
  // ----------------------------------------------------------------------
  always @(negedge we_n) begin
    armed = !ce_n && oe_n && reset_n;
    wa    = addr;
    wd    = dq_in;
  end
  // command taken on the rising strobe; ce may rise in the same step
  always @(posedge we_n) begin
    if (armed) begin
      armed = 1'b0;
      if (busy && !tle) begin
        n_busy_wr = n_busy_wr + 8'h01;
      end else if (wd == `FPS_RESET_CMD) begin
        {step, busy, tle} = '0;
      end else if (!busy) begin
        case (step)
          2'h0: step = (wa == `FPS_UNLOCK1_ADDR && wd == `FPS_UNLOCK1_DATA) ? 2'h1 : 2'h0;
          2'h1: step = (wa == `FPS_UNLOCK2_ADDR && wd == `FPS_UNLOCK2_DATA) ? 2'h2 : 2'h0;
          2'h2: step = (wa == `FPS_UNLOCK1_ADDR && wd == `FPS_SETUP_CMD) ? 2'h3 : 2'h0;
          default: begin
            {step, pa, pd, busy} = {2'h0, wa, wd, 1'b1};
            gen = gen + 1;
            run_prog(gen);
          end
        endcase
      end
    end
  end
  // internal algorithm; the limit mode never finishes on its own
  task automatic run_prog(input int g);
    fork
      begin
        #(PROG_NS);
        if (g == gen && busy) begin
          if (fail_mode) tle = 1'b1;
          else begin
            mem[pa] = rd_mem(pa) & pd;
            busy = 1'b0;
          end
        end
      end
    join_none
  endtask : run_prog
  // hardware reset drops the running operation at once
  always @(negedge reset_n) begin
    gen = gen + 1;
    {step, busy, tle} = '0;
  end
  // ----------------------------------------------------------------------
  // read cycles: wrong byte until access time, then the answer
  // ----------------------------------------------------------------------
  always @(negedge oe_n) begin
    if (!ce_n) begin
      if (busy) begin
        if (addr != pa) n_bad_rd = n_bad_rd + 8'h01;
        tog   = ~tog;
        rbyte = {~pd[7], tog, tle, pd[4:3], 1'b0, pd[1:0]};
      end else rbyte = rd_mem(addr);
      dq_out = ~rbyte;
      dq_oe  = 1'b1;
      #60;
      if (!oe_n) dq_out = rbyte;
    end
  end
  always @(posedge oe_n) dq_oe = 1'b0;
endmodule : fps_flash_model
`default_nettype wire

// ### fps_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fps_params.svh"
module fps_ctrl_tb
  import fps_pkg::*;
;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, fail_mode;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, lfsr;
  logic [19:0] fl_addr;
  logic [7:0]  fl_dq_out, fl_dq_in, m_dq, n_busy_wr, n_bad_rd;
  logic        fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, m_oe, m_rb_low, fl_rb;
  int          n_fail, checked;
  logic [7:0]  shadow [int];  // what the array should hold
  assign fl_dq_in = m_oe ? m_dq : ~m_dq;  // released bus shows the inverse of its last byte
  assign fl_rb    = ~m_rb_low;            // pull-up unless the flash pulls low
  fps_ctrl i_fps_ctrl (
    .MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HREADY(hreadyout), .HWDATA(hwdata), .HREADYOUT(hreadyout), .HRDATA(hrdata),
    .HRESP(hresp), .FL_ADDR(fl_addr), .FL_DQ_IN(fl_dq_in), .FL_DQ_OUT(fl_dq_out),
    .FL_DQ_OE(fl_dq_oe), .FL_CE_N(fl_ce_n), .FL_WE_N(fl_we_n), .FL_OE_N(fl_oe_n),
    .FL_RESET_N(fl_reset_n), .FL_READY_BUSY(fl_rb));
  fps_flash_model #(.PROG_NS(2000)) i_fps_flash_model (
    .addr(fl_addr), .dq_in(fl_dq_out), .ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n),
    .reset_n(fl_reset_n), .dq_out(m_dq), .dq_oe(m_oe), .rb_low(m_rb_low),
    .fail_mode(fail_mode), .n_busy_wr(n_busy_wr), .n_bad_rd(n_bad_rd));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] old_byte(input logic [19:0] a);
    return shadow.exists(a) ? shadow[a] : 8'hFF;
  endfunction : old_byte
  // status after a finished order: idle, done, pin released
  function automatic logic [31:0] exp_done(input logic [7:0] rd, input logic fl);
    return {16'h0, rd, 3'h0, 1'b1, 1'b0, fl, 1'b1, 1'b0};
  endfunction : exp_done
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // one single transfer; each phase held until hready is seen high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    if (w) hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask : rd
  // wait for busy to show, then for it to clear, both bounded
  task automatic wait_done(output logic [31:0] st);
    int i;
    st = 32'h0;
    for (i = 0; i < 20 && st[0] !== 1'b1; i++) rd(8'h0C, st);
    for (i = 0; i < 3000 && st[0] !== 1'b0; i++) rd(8'h0C, st);
  endtask : wait_done
  // full program order; a second go while busy must be dropped
  task automatic prog(input logic [19:0] a, input logic [7:0] d, input logic twice);
    logic [31:0] st;
    logic [7:0]  e;
    e = old_byte(a) & d;
    wr(8'h04, {12'h0, a});
    wr(8'h08, {24'h0, d});
    wr(8'h00, 32'h1);
    if (twice) wr(8'h00, 32'h1);
    wait_done(st);
    chk("program status", exp_done(e, e != d), st);
    shadow[a] = e;
  endtask : prog
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [19:0] a;
    int          i;
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, fail_mode} = '0;
    {n_fail, checked} = '0;
    lfsr = 32'h3E7F;
    a    = 20'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h0C, q);
    chk("status after reset", 32'h10, q);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, q);
    chk("unmapped word", 32'h0, q);
    lfsr = lfsr_next(lfsr);
    wr(8'h04, lfsr);
    rd(8'h04, q);
    chk("address register", {12'h0, lfsr[19:0]}, q);
    wr(8'h08, lfsr);
    rd(8'h08, q);
    chk("data register", {24'h0, lfsr[7:0]}, q);
    // random programs with an unlock address, the top address and a rewrite
    for (i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i == 1) ? 20'h00555 : (i == 2) ? 20'hFFFFF : (i == 4) ? a : lfsr[19:0];
      prog(a, lfsr[27:20], i == 5);
    end
    wr(8'h00, 32'h2);
    wait_done(q);
    chk("reset command status", 32'h12, {27'h0, q[4:0]});
    // flash overruns its pulse limit, then must take work again
    fail_mode <= 1'b1;
    wr(8'h04, 32'h00123);
    wr(8'h08, 32'h5A);
    wr(8'h00, 32'h1);
    wait_done(q);
    chk("time limit status", 32'h16, {27'h0, q[4:0]});
    fail_mode <= 1'b0;
    prog(20'h00123, 8'h5A, 1'b0);
    // hardware reset in mid program, then the order is issued again
    wr(8'h04, 32'h00ABC);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    q = 32'h10;
    for (i = 0; i < 50 && q[4] !== 1'b0; i++) rd(8'h0C, q);
    chk("busy while pin low", 32'h1, {31'h0, q[0]});
    wr(8'h00, 32'h4);
    wait_done(q);
    chk("hardware reset status", 32'h1A, {27'h0, q[4:0]});
    prog(20'h00ABC, 8'h00, 1'b0);
    chk("writes while busy", 32'h0, {24'h0, n_busy_wr});
    chk("reads off address", 32'h0, {24'h0, n_bad_rd});
    end_sim();
  end
  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail = n_fail + 1;
    end_sim();
  end
endmodule : fps_ctrl_tb
`default_nettype wire
